/* shared/mda_map.vh */
// constants and field layout of the two-wire target front end
`ifndef MDA_MAP_VH
`define MDA_MAP_VH

// ==========================================
// address byte
`define MDA_ADDR_BASE   5'h13
`define MDA_BCAST_ADDR  7'h48
`define MDA_RW_BIT      0

// ==========================================
// control byte fields
`define MDA_EXT_HI_BIT  7
`define MDA_EXT_LO_BIT  6
`define MDA_LOAD_HI_BIT 5
`define MDA_LOAD_LO_BIT 4
`define MDA_CHAN_HI_BIT 2
`define MDA_CHAN_LO_BIT 1
`define MDA_PD_BIT      0

// ==========================================
// load field codes
`define MDA_LOAD_STORE  2'h0
`define MDA_LOAD_DIRECT 2'h1
`define MDA_LOAD_ALL    2'h2
`define MDA_LOAD_BCAST  2'h3

// ==========================================
// power-down mode in high data byte
`define MDA_PDM_HI_BIT  7
`define MDA_PDM_LO_BIT  6

// ==========================================
// bit counter: eight data bits then the acknowledge slot
`define MDA_ACK_SLOT    4'h8

`endif

/* hdl/mda_pin_sync.v */
// two-flop synchroniser with edge detection for the serial pins
`timescale 1ns/1ns
`default_nettype none
module mda_pin_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // asynchronous pins
  input  wire [WIDTH-1:0] pin_in,
  // synchronised level and edges
  output wire [WIDTH-1:0] lvl,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  reg [WIDTH-1:0] prev_r;

  // ==========================================
  // the first stage feeds only the second; edges come from stages two and three
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b1}};
      sync_r <= {WIDTH{1'b1}};
      prev_r <= {WIDTH{1'b1}};
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign lvl  = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule
`default_nettype wire

/* hdl/mda_i2c_target.v */
// two-wire target front end with extended addressing for a four-channel converter
`timescale 1ns/1ns
`default_nettype none
`include "mda_map.vh"
module mda_i2c_target #(
  parameter CODE_W = 16,
  parameter NCH    = 4
) (
  // clock and reset
  input  wire                  clk,
  input  wire                  rst_n,
  // serial bus pins
  input  wire                  scl_in,
  input  wire                  sda_in,
  output wire                  sda_out,
  output wire                  sda_oe_n,
  // address straps
  input  wire                  bus_addr_sel_pin_lo,
  input  wire                  bus_addr_sel_pin_hi,
  input  wire                  ext_addr_pin_lo,
  input  wire                  ext_addr_pin_hi,
  // channel outputs
  output reg  [NCH*CODE_W-1:0] dac_code,
  output reg  [NCH-1:0]        dac_pd,
  output reg  [NCH*2-1:0]      dac_pd_mode,
  output reg                   update_pulse
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CTRL = 3'h2;
  localparam ST_MSB  = 3'h3;
  localparam ST_LSB  = 3'h4;
  localparam ST_SKIP = 3'h5;

  // ==========================================
  // pin synchronisation
  wire [5:0] lvl;
  wire [5:0] rise;
  wire [5:0] fall;

  mda_pin_sync #(.WIDTH(6)) u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in ({ext_addr_pin_hi, ext_addr_pin_lo, bus_addr_sel_pin_hi,
              bus_addr_sel_pin_lo, sda_in, scl_in}),
    .lvl    (lvl),
    .rise   (rise),
    .fall   (fall)
  );

  wire       scl_lvl  = lvl[0];
  wire       scl_rise = rise[0];
  wire       scl_fall = fall[0];
  wire       sda_lvl  = lvl[1];
  wire [1:0] bus_sel  = lvl[3:2];
  wire [1:0] ext_sel  = lvl[5:4];
  wire       start_ev = fall[1] & scl_lvl;
  wire       stop_ev  = rise[1] & scl_lvl;

  // ==========================================
  // address decode
  function addr_hit;
    input [7:0] b;
    input [1:0] sel;
    begin
      addr_hit = (b[`MDA_RW_BIT] == 1'b0) &&
                 ((b[7:1] == {`MDA_ADDR_BASE, sel}) ||
                  (b[7:1] == `MDA_BCAST_ADDR));
    end
  endfunction

  // ==========================================
  // channel decode; a broadcast load selects every channel
  function chan_hit;
    input [1:0] ld;
    input [1:0] ch;
    input [1:0] idx;
    begin
      chan_hit = (ld == `MDA_LOAD_BCAST) || (ch == idx);
    end
  endfunction

  // ==========================================
  // extended address gate; a broadcast load ignores the straps
  function ext_hit;
    input [1:0] cbits;
    input [1:0] ld;
    input [1:0] straps;
    begin
      ext_hit = (cbits == straps) || (ld == `MDA_LOAD_BCAST);
    end
  endfunction

  // ==========================================
  // state
  reg [2:0]            state_r;
  reg [3:0]            cnt_r;
  reg                  ackph_r;
  reg                  oe_n_r;
  reg [7:0]            shift_r;
  reg [7:0]            ctrl_r;
  reg [7:0]            msb_r;
  reg                  commit_r;
  reg [NCH*CODE_W-1:0] tmp_code_r;
  reg [NCH-1:0]        tmp_pd_r;
  reg [NCH*2-1:0]      tmp_mode_r;

  wire [1:0] load_f = ctrl_r[`MDA_LOAD_HI_BIT:`MDA_LOAD_LO_BIT];
  wire [1:0] chan_f = ctrl_r[`MDA_CHAN_HI_BIT:`MDA_CHAN_LO_BIT];
  wire [1:0] sh_ext = shift_r[`MDA_EXT_HI_BIT:`MDA_EXT_LO_BIT];
  wire [1:0] sh_ld  = shift_r[`MDA_LOAD_HI_BIT:`MDA_LOAD_LO_BIT];

  assign sda_out  = 1'b0;
  assign sda_oe_n = oe_n_r;

  integer i;

  // ==========================================
  // byte engine; the acknowledge is driven from the falling clock after bit eight
  // until the falling clock that ends the acknowledge slot
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_IDLE;
      cnt_r        <= 4'h0;
      ackph_r      <= 1'b0;
      oe_n_r       <= 1'b1;
      shift_r      <= 8'h00;
      ctrl_r       <= 8'h00;
      msb_r        <= 8'h00;
      commit_r     <= 1'b0;
      tmp_code_r   <= {NCH*CODE_W{1'b0}};
      tmp_pd_r     <= {NCH{1'b0}};
      tmp_mode_r   <= {NCH*2{1'b0}};
      dac_code     <= {NCH*CODE_W{1'b0}};
      dac_pd       <= {NCH{1'b0}};
      dac_pd_mode  <= {NCH*2{1'b0}};
      update_pulse <= 1'b0;
    end else begin
      update_pulse <= 1'b0;
      if (start_ev) begin
        state_r  <= ST_ADDR;
        cnt_r    <= 4'h0;
        ackph_r  <= 1'b0;
        oe_n_r   <= 1'b1;
        commit_r <= 1'b0;
      end else if (stop_ev) begin
        state_r  <= ST_IDLE;
        ackph_r  <= 1'b0;
        oe_n_r   <= 1'b1;
        commit_r <= 1'b0;
      end else if (state_r != ST_IDLE) begin
        if (scl_rise && cnt_r != `MDA_ACK_SLOT) begin
          shift_r <= {shift_r[6:0], sda_lvl};
          cnt_r   <= cnt_r + 4'h1;
        end else if (scl_fall && cnt_r == `MDA_ACK_SLOT && !ackph_r) begin
          ackph_r <= 1'b1;
          oe_n_r  <= 1'b0;
          case (state_r)
            ST_ADDR: begin
              if (addr_hit(shift_r, bus_sel)) begin
                state_r <= ST_CTRL;
              end else begin
                state_r <= ST_IDLE;
                ackph_r <= 1'b0;
                oe_n_r  <= 1'b1;
              end
            end
            ST_CTRL: begin
              // a mismatched device still acknowledges, so shared addresses ack together
              ctrl_r <= shift_r;
              if (ext_hit(sh_ext, sh_ld, ext_sel)) begin
                state_r <= ST_MSB;
              end else begin
                state_r <= ST_SKIP;
              end
            end
            ST_MSB: begin
              msb_r   <= shift_r;
              state_r <= ST_LSB;
            end
            ST_LSB: begin
              commit_r <= 1'b1;
              state_r  <= ST_MSB;
            end
            ST_SKIP: begin
              state_r <= ST_SKIP;
            end
            default: begin
              state_r <= ST_IDLE;
            end
          endcase
        end else if (scl_fall && ackph_r) begin
          ackph_r  <= 1'b0;
          oe_n_r   <= 1'b1;
          cnt_r    <= 4'h0;
          commit_r <= 1'b0;
          if (commit_r) begin
            update_pulse <= (load_f != `MDA_LOAD_STORE);
            for (i = 0; i < NCH; i = i + 1) begin
              if (chan_hit(load_f, chan_f, i[1:0])) begin
                tmp_code_r[i*CODE_W +: CODE_W] <= {msb_r, shift_r};
                tmp_pd_r[i]                    <= ctrl_r[`MDA_PD_BIT];
                tmp_mode_r[i*2 +: 2]           <= msb_r[`MDA_PDM_HI_BIT:`MDA_PDM_LO_BIT];
                if (load_f != `MDA_LOAD_STORE) begin
                  dac_code[i*CODE_W +: CODE_W] <= {msb_r, shift_r};
                  dac_pd[i]                    <= ctrl_r[`MDA_PD_BIT];
                  dac_pd_mode[i*2 +: 2]        <= msb_r[`MDA_PDM_HI_BIT:`MDA_PDM_LO_BIT];
                end
              end else if (load_f == `MDA_LOAD_ALL) begin
                // other channels move to their stored values in the same edge
                dac_code[i*CODE_W +: CODE_W] <= tmp_code_r[i*CODE_W +: CODE_W];
                dac_pd[i]                    <= tmp_pd_r[i];
                dac_pd_mode[i*2 +: 2]        <= tmp_mode_r[i*2 +: 2];
              end
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

/* verification/mda_asserts.sv */
// port assertions for the two-wire target
`timescale 1ns/1ns
`default_nettype none
module mda_asserts #(
  parameter CODE_W = 16,
  parameter NCH    = 4
) (
  // clock, reset and bus
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    scl_in,
  input wire logic                    sda_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe_n,
  // straps
  input wire logic                    bus_addr_sel_pin_lo,
  input wire logic                    bus_addr_sel_pin_hi,
  input wire logic                    ext_addr_pin_lo,
  input wire logic                    ext_addr_pin_hi,
  // channel outputs
  input wire logic [NCH*CODE_W-1:0]   dac_code,
  input wire logic [NCH-1:0]          dac_pd,
  input wire logic [NCH*2-1:0]        dac_pd_mode,
  input wire logic                    update_pulse
);
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // an ack slot spans a whole scl cycle, so six clocks is a safe floor
  sequence ack_low; !sda_oe_n [*6]; endsequence
  sequence no_pulse; !update_pulse [*8]; endsequence
  AST_CODE_HELD: assert property (!update_pulse |-> $stable(dac_code))
    else $error("channel code changed without an update");
  AST_PD_HELD: assert property (!update_pulse |-> $stable(dac_pd))
    else $error("power-down flag changed without an update");
  AST_MODE_HELD: assert property (!update_pulse |-> $stable(dac_pd_mode))
    else $error("power-down mode changed without an update");
  AST_PULSE_SINGLE: assert property (update_pulse |=> no_pulse)
    else $error("update pulse repeated");
  AST_PULSE_AT_ACK_END: assert property (update_pulse |-> $rose(sda_oe_n) && !scl_in)
    else $error("update not at the end of the ack slot");
  AST_ACK_SLOT: assert property ($fell(sda_oe_n) |-> ack_low)
    else $error("ack released too early");
  AST_ACK_IN_LOW: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("ack started while scl high");
  AST_RELEASE_IN_LOW: assert property ($rose(sda_oe_n) |-> !scl_in)
    else $error("ack released while scl high");
endmodule
`default_nettype wire

/* verification/mda_bus_ctrl.sv */
// bus controller model: open-drain writes, scl still between frames
`timescale 1ns/1ns
`default_nettype none
module mda_bus_ctrl (
  // clock and wire
  input wire logic  clk,
  input wire logic  sda_wire,
  // driven lines
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // ==========
  // byte and frame
  task automatic tx(input logic [7:0] v, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = v[i];
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
    end
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 ak = !sda_wire;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic xfer(input logic [31:0] w, input logic [16:0] x, output logic [5:0] ak);
    ak = 6'h00;
    @(posedge clk);
    #2 sda_drv = 1'b0;
    #80 scl = 1'b0;
    #40;
    tx(w[31:24], ak[3]);
    // a refused address ends the frame at once
    if (ak[3]) begin
      tx(w[23:16], ak[2]);
      tx(w[15:8], ak[1]);
      tx(w[7:0], ak[0]);
      // an optional second pair reuses the same control byte
      if (x[16]) begin
        tx(x[15:8], ak[5]);
        tx(x[7:0], ak[4]);
      end
    end
    sda_drv = 1'b0;
    #40 scl = 1'b1;
    #80 sda_drv = 1'b1;
    #80;
  endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// random write bench against a behavioural channel model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int CODE_W = 16;
  localparam int NCH    = 4;
  logic        clk, rst_n, bus_lo, bus_hi, ext_lo, ext_hi, aok, act;
  wire         scl_in, sda_drv, sda_out, sda_oe_n, update_pulse;
  wire [63:0]  dac_code;
  wire [3:0]   dac_pd;
  wire [7:0]   dac_pd_mode;
  wire         sda_wire = sda_drv & (sda_oe_n | sda_out);
  int          num_errors, total_checks, cyc, pulses, ch, np;
  int          tc[4], tp[4], tm[4], oc[4], op[4], om[4];
  logic [31:0] seed, w;
  logic [63:0] ec;
  logic [7:0]  em, mk;
  logic [3:0]  ep;
  logic [5:0]  ak;
  logic [16:0] xw;
  logic [15:0] dw;
  logic [1:0]  ld;
  mda_i2c_target #(.CODE_W(CODE_W), .NCH(NCH)) dut_u (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_addr_sel_pin_lo(bus_lo),
    .bus_addr_sel_pin_hi(bus_hi), .ext_addr_pin_lo(ext_lo), .ext_addr_pin_hi(ext_hi),
    .dac_code(dac_code), .dac_pd(dac_pd), .dac_pd_mode(dac_pd_mode), .update_pulse(update_pulse));
  mda_bus_ctrl ctrl_u (.clk(clk), .sda_wire(sda_wire), .scl(scl_in), .sda_drv(sda_drv));
  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the ceiling covers eighty frames of at most about 460 clocks each
  always @(posedge clk) begin
    cyc++;
    if (update_pulse === 1'b1) pulses++;
    if (cyc == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ==========
  // main sequence
  initial begin
    rst_n = 1'b0;
    {ext_hi, ext_lo, bus_hi, bus_lo} = 4'h0;
    seed = 32'h864a;
    repeat (5) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    for (int n = 0; n < 80; n++) begin
      repeat (8) seed = lfsr(seed);
      @(posedge clk);
      #2 {ext_hi, ext_lo, bus_hi, bus_lo} = seed[3:0];
      ld = seed[6:5];
      repeat (8) seed = lfsr(seed);
      w = seed;
      repeat (8) seed = lfsr(seed);
      xw = seed[16:0];
      if (ld == 2'h0) w[31:24] = {5'h13, bus_hi, bus_lo, 1'b0};
      if (ld == 2'h1) w[31:24] = 8'h90;
      if (ld == 2'h2) w[31:24] = {5'h13, bus_hi, bus_lo, 1'b1};
      if (w[3]) w[23:22] = {ext_hi, ext_lo};
      aok = !w[24] && (w[31:25] == 7'h48 || w[31:25] == {5'h13, bus_hi, bus_lo});
      ld = w[21:20];
      ch = w[18:17];
      act = aok && (ld == 2'h3 || w[23:22] == {ext_hi, ext_lo});
      np = xw[16] ? 2 : 1;
      pulses = 0;
      ctrl_u.xfer(w, xw, ak);
      check(ak, aok ? (xw[16] ? 6'h3f : 6'h0f) : 6'h00);
      for (int p = 0; p < np; p++) begin
        dw = (p == 0) ? w[15:0] : xw[15:0];
        for (int k = 0; k < 4; k++) begin
          if (act && (ld == 2'h3 || k == ch)) begin
            tc[k] = dw;
            tp[k] = w[16];
            tm[k] = dw[15:14];
          end
        end
        for (int k = 0; k < 4; k++) begin
          if (act && ld != 2'h0 && (ld != 2'h1 || k == ch)) begin
            oc[k] = tc[k];
            op[k] = tp[k];
            om[k] = tm[k];
          end
        end
      end
      for (int k = 0; k < 4; k++) begin
        ec[16*k+:16] = oc[k][15:0];
        ep[k] = op[k][0];
        em[2*k+:2] = om[k][1:0];
        mk[2*k+:2] = {2{ep[k]}};
      end
      check(pulses, (act && ld != 2'h0) ? np : 0);
      check(dac_code, ec);
      check(dac_pd, ep);
      check(dac_pd_mode & mk, em & mk);
    end
    give_verdict();
  end
endmodule
bind mda_i2c_target mda_asserts #(.CODE_W(CODE_W), .NCH(NCH)) chk_u (.clk(clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .bus_addr_sel_pin_lo(bus_addr_sel_pin_lo), .bus_addr_sel_pin_hi(bus_addr_sel_pin_hi),
  .ext_addr_pin_lo(ext_addr_pin_lo), .ext_addr_pin_hi(ext_addr_pin_hi), .dac_code(dac_code),
  .dac_pd(dac_pd), .dac_pd_mode(dac_pd_mode), .update_pulse(update_pulse));
`default_nettype wire
